// ===== logic/prw_core.sv
/*
  Position-range tracker of a motor drive: keeps the reference position
  in user units inside the signed movement range, keeps the zero-point
  valid flag, and handles wrap, internal reset to 0 or refusal when a
  move leaves the range. Also owns the active scaling ratio.
  Assumes one clock, commands synchronous to it from the mode logic,
  and a motion generator that supplies a per-cycle speed in user units.
*/
// Notes on behaviour
// - With factory scaling the position stays within -1073741824 to 1073741823 user units.
// - Range handling and motion commands act only in jog, profile position, homing and CSP.
// - Absolute profile targets are taken relative to the current zero point.
// - The zero point is set and marked valid only by a finished homing or a position set.
// - Homing-done and position-set requests are accepted only in homing mode.
// - Any move that carries the position past a range end clears the zero-valid flag.
// - Continuous jog wraps the position to the opposite end and keeps moving.
// - A jog step with a target outside the range first resets the position to 0.
// - A relative profile move with a target outside the range first resets the position to 0.
// - An absolute profile move to a target beyond the range is refused.
// - Every position exchanged with users is in user units.
// - User positions are turned into internal increments and back for reporting.
// - After a scaling change stored user values are reinterpreted with the new ratio.
// - Internal tracking uses 32768 increments per motor revolution.
// - Factory scaling makes one revolution equal 16384 user units.
// - A new ratio takes effect only on a numerator write; a denominator write alone waits.
`default_nettype none

`include "prw_regs.svh"

module prw_core
  import prw_pkg::*;
#(
  parameter int unsigned INC_PER_REV = 32768
) (
  input  wire logic                clk_i,
  input  wire logic                resetn_i,
  input  wire prw_mode_t           mode_i,
  input  wire prw_cmd_t            cmd_i,
  input  wire logic [30:0]         speed_i,
  input  wire prw_scale_wr_t       scale_wr_i,
  input  wire logic signed [63:0]  act_inc_i,
  output logic signed [31:0]       pos_usr_o,
  output logic signed [31:0]       target_usr_o,
  output logic signed [63:0]       ref_inc_o,
  output logic signed [31:0]       act_usr_o,
  output logic [31:0]              scale_num_o,
  output logic [31:0]              scale_den_o,
  output var prw_status_t          status_o
);

  if (INC_PER_REV != 32'(`PRW_INC_PER_REV)) begin : g_bad_res
    $error("prw_core: internal resolution must match the range constants");
  end

  typedef enum logic [1:0] {
    PRW_ST_IDLE = 2'h0,
    PRW_ST_JOG  = 2'h1,
    PRW_ST_MOVE = 2'h2
  } prw_state_t;

  prw_state_t          state;
  logic signed [33:0]  pos;
  logic signed [33:0]  target;
  logic                jog_neg;
  logic [31:0]         den_pend;

  logic                mode_ok;
  logic                kind_ok;
  logic                accept;
  logic signed [33:0]  val34;
  logic signed [33:0]  spd34;
  logic signed [33:0]  rel_sum;
  logic signed [33:0]  jog_sum;
  logic signed [33:0]  diff;
  logic                rel_out;
  logic                val_out;
  logic                jog_over;
  logic                arrive;
  logic                run;
  logic                crossing;
  logic                zero_valid;
  logic                busy;
  logic                done;
  logic                reject;
  logic                range_evt;

  function automatic logic prw_outside(input logic signed [33:0] p);
    prw_outside = (p > signed'(`PRW_POS_MAX)) || (p < signed'(`PRW_POS_MIN));
  endfunction : prw_outside

  assign mode_ok = (mode_i == PRW_MODE_JOG) || (mode_i == PRW_MODE_PP)
                || (mode_i == PRW_MODE_HOMING) || (mode_i == PRW_MODE_CSP);

  // Each command other than STOP belongs to exactly one mode; STOP works in all range modes
  always_comb begin
    unique case (cmd_i.kind)
      PRW_CMD_STOP:      kind_ok = mode_ok;
      PRW_CMD_JOG_CONT:  kind_ok = (mode_i == PRW_MODE_JOG);
      PRW_CMD_JOG_STEP:  kind_ok = (mode_i == PRW_MODE_JOG);
      PRW_CMD_PP_REL:    kind_ok = (mode_i == PRW_MODE_PP);
      PRW_CMD_PP_ABS:    kind_ok = (mode_i == PRW_MODE_PP);
      PRW_CMD_HOME_DONE: kind_ok = (mode_i == PRW_MODE_HOMING);
      PRW_CMD_SET_POS:   kind_ok = (mode_i == PRW_MODE_HOMING);
      PRW_CMD_CSP_SET:   kind_ok = (mode_i == PRW_MODE_CSP);
    endcase
  end

  // Arithmetic on 34 bits so a sum past either end is still seen
  always_comb begin
    val34    = 34'(cmd_i.value);
    spd34    = signed'({3'h0, speed_i});
    rel_sum  = pos + val34;
    jog_sum  = jog_neg ? (pos - spd34) : (pos + spd34);
    diff     = target - pos;
    rel_out  = prw_outside(rel_sum);
    val_out  = prw_outside(val34);
    jog_over = prw_outside(jog_sum);
    arrive   = (diff <= spd34) && (diff >= -spd34);
    // Out-of-range absolute targets and impossible relatives are refused
    accept   = cmd_i.valid && kind_ok && !val_out;
    run      = mode_ok && !(cmd_i.valid && kind_ok); // Motion owns this cycle
    crossing = (run && (state == PRW_ST_JOG) && jog_over)
            || (accept && rel_out && ((cmd_i.kind == PRW_CMD_JOG_STEP)
            || (cmd_i.kind == PRW_CMD_PP_REL)));
  end

  // Position, target and motion state
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state   <= PRW_ST_IDLE;
      pos     <= 34'h0;
      target  <= 34'h0;
      jog_neg <= 1'b0;
    end else if (!mode_ok) begin
      state  <= PRW_ST_IDLE;
      target <= pos;
    end else if (cmd_i.valid && kind_ok) begin
      unique case (cmd_i.kind)
        PRW_CMD_STOP: begin
          state  <= PRW_ST_IDLE;
          target <= pos;
        end
        PRW_CMD_JOG_CONT: begin
          state   <= PRW_ST_JOG;
          jog_neg <= cmd_i.value[31];
        end
        PRW_CMD_JOG_STEP,
        PRW_CMD_PP_REL: begin
          if (!val_out) begin
            state <= PRW_ST_MOVE;
            if (rel_out) begin
              pos    <= 34'h0;
              target <= val34;
            end else begin
              target <= rel_sum;
            end
          end
        end
        PRW_CMD_PP_ABS: begin
          if (!val_out) begin
            state  <= PRW_ST_MOVE;
            target <= val34;
          end
        end
        PRW_CMD_HOME_DONE,
        PRW_CMD_SET_POS: begin
          if (!val_out) begin
            state  <= PRW_ST_IDLE;
            pos    <= val34;
            target <= val34;
          end
        end
        PRW_CMD_CSP_SET: begin
          if (!val_out) begin
            pos    <= val34;
            target <= val34;
          end
        end
      endcase
    end else begin
      unique case (state)
        PRW_ST_IDLE: begin
          target <= pos;
        end
        PRW_ST_JOG: begin
          if (jog_sum > signed'(`PRW_POS_MAX)) begin
            pos <= jog_sum - signed'(`PRW_POS_SPAN);
          end else if (jog_sum < signed'(`PRW_POS_MIN)) begin
            pos <= jog_sum + signed'(`PRW_POS_SPAN);
          end else begin
            pos <= jog_sum;
          end
          target <= pos;
        end
        PRW_ST_MOVE: begin
          if (arrive) begin
            pos   <= target;
            state <= PRW_ST_IDLE;
          end else if (diff[33]) begin
            pos <= pos - spd34;
          end else begin
            pos <= pos + spd34;
          end
        end
        default: begin
          state <= PRW_ST_IDLE;
        end
      endcase
    end
  end

  // Event pulses: done on arrival, reject, range crossing or reset
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      done      <= 1'b0;
      reject    <= 1'b0;
      range_evt <= 1'b0;
    end else begin
      done   <= run && (state == PRW_ST_MOVE) && arrive;
      reject <= cmd_i.valid && !accept;
      range_evt <= crossing;
    end
  end

  // Zero-point flag; a set in the same cycle as a crossing wins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      zero_valid <= 1'b0;
    end else if (accept && ((cmd_i.kind == PRW_CMD_HOME_DONE)
                         || (cmd_i.kind == PRW_CMD_SET_POS))) begin
      zero_valid <= 1'b1;
    end else if (crossing) begin
      zero_valid <= 1'b0;
    end
  end

  // scaling ratio; zero writes are ignored, the ratio needs >= 1
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scale_num_o <= `PRW_FACT_NUM;
      scale_den_o <= `PRW_FACT_DEN;
      den_pend    <= `PRW_FACT_DEN;
    end else if (scale_wr_i.num_we && (scale_wr_i.value != 32'h0)
                 && !scale_wr_i.value[31]) begin
      scale_num_o <= scale_wr_i.value;
      scale_den_o <= den_pend;
    end else if (scale_wr_i.den_we && (scale_wr_i.value != 32'h0)
                 && !scale_wr_i.value[31]) begin
      den_pend <= scale_wr_i.value;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pos_usr_o    <= 32'h0;
      target_usr_o <= 32'h0;
      busy         <= 1'b0;
    end else begin
      pos_usr_o    <= pos[31:0];
      target_usr_o <= target[31:0];
      busy         <= (state != PRW_ST_IDLE);
    end
  end

  // One driver for the whole bundle; the flags themselves are flops
  assign status_o = {zero_valid, busy, done, reject, range_evt};

  // conversion always uses the live ratio
  prw_scaler #(
    .INC_PER_REV (INC_PER_REV)
  ) u_scaler (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .num_i     (scale_num_o),
    .den_i     (scale_den_o),
    .pos_usr_i (pos_usr_o),
    .act_inc_i (act_inc_i),
    .ref_inc_o (ref_inc_o),
    .act_usr_o (act_usr_o)
  );

endmodule : prw_core

`default_nettype wire

// ===== logic/prw_regs.svh
/*
  Constants of the position-range tracker: range ends, wrap span,
  internal resolution and factory scaling.
  Assumes it is included by bare name, before the package and modules.
*/
`ifndef PRW_REGS_SVH
`define PRW_REGS_SVH

// Movement range ends in user units, factory scaling
`define PRW_POS_MIN      34'h3C0000000
`define PRW_POS_MAX      34'h03FFFFFFF
// Width of the range, used for modular wrap
`define PRW_POS_SPAN     34'h080000000
// Internal increments per motor revolution
`define PRW_INC_PER_REV  32'h00008000
// Factory scaling: one revolution per 16384 user units
`define PRW_FACT_NUM     32'h00000001
`define PRW_FACT_DEN     32'h00004000

`endif

// ===== logic/prw_pkg.sv
/*
  Types of the position-range tracker: operating modes, motion
  commands, scaling writes and the status bundle.
  Assumes prw_regs.svh sits beside it.
*/
`default_nettype none

package prw_pkg;

  // Operating mode reported by the drive's mode logic
  typedef enum logic [2:0] {
    PRW_MODE_OTHER  = 3'h0,
    PRW_MODE_JOG    = 3'h1,
    PRW_MODE_PP     = 3'h2,
    PRW_MODE_HOMING = 3'h3,
    PRW_MODE_CSP    = 3'h4
  } prw_mode_t;

  // Motion command kinds
  typedef enum logic [2:0] {
    PRW_CMD_STOP      = 3'h0,
    PRW_CMD_JOG_CONT  = 3'h1,
    PRW_CMD_JOG_STEP  = 3'h2,
    PRW_CMD_PP_REL    = 3'h3,
    PRW_CMD_PP_ABS    = 3'h4,
    PRW_CMD_HOME_DONE = 3'h5,
    PRW_CMD_SET_POS   = 3'h6,
    PRW_CMD_CSP_SET   = 3'h7
  } prw_cmd_kind_t;

  // Motion command, value in user units
  typedef struct packed {
    logic                valid;
    prw_cmd_kind_t       kind;
    logic signed [31:0]  value;
  } prw_cmd_t;

  // Scaling write: numerator write activates the ratio
  typedef struct packed {
    logic         num_we;
    logic         den_we;
    logic [31:0]  value;
  } prw_scale_wr_t;

  // Status flags and one-cycle event pulses
  typedef struct packed {
    logic  zero_valid;
    logic  busy;
    logic  done;
    logic  reject;
    logic  range_evt;
  } prw_status_t;

endpackage : prw_pkg

`default_nettype wire

// ===== logic/prw_scaler.sv
/*
  Converts a user-unit position to internal increments and an internal
  position back to user units, with one register stage each way.
  Assumes num and den are at least 1; the owner guarantees this.
*/
`default_nettype none

`include "prw_regs.svh"

module prw_scaler
  import prw_pkg::*;
#(
  parameter int unsigned INC_PER_REV = 32768
) (
  input  wire logic                clk_i,
  input  wire logic                resetn_i,
  input  wire logic [31:0]         num_i,
  input  wire logic [31:0]         den_i,
  input  wire logic signed [31:0]  pos_usr_i,
  input  wire logic signed [63:0]  act_inc_i,
  output logic signed [63:0]       ref_inc_o,
  output logic signed [31:0]       act_usr_o
);

  if (INC_PER_REV < 1 || INC_PER_REV > 32'h00010000) begin : g_bad_res
    $error("prw_scaler: resolution out of supported range");
  end

  logic signed [95:0] rev_inc;
  logic signed [95:0] usr_num;
  logic signed [95:0] inc_den;
  logic signed [95:0] q_inc;
  logic signed [95:0] q_usr;

  // Wide signed products so no ratio in the legal range can overflow
  always_comb begin
    rev_inc = 96'(signed'({1'b0, num_i})) * 96'(signed'({1'b0, 32'(INC_PER_REV)}));
    usr_num = 96'(pos_usr_i) * rev_inc;
    inc_den = 96'(act_inc_i) * 96'(signed'({1'b0, den_i}));
    q_inc   = usr_num / 96'(signed'({1'b0, den_i}));
    q_usr   = inc_den / rev_inc;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_inc_o <= 64'h0;
    end else begin
      ref_inc_o <= q_inc[63:0];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      act_usr_o <= 32'h0;
    end else begin
      act_usr_o <= q_usr[31:0];
    end
  end

endmodule : prw_scaler

`default_nettype wire

// ===== verification/prw_drive_model.sv
/*
  Motor seen from the tracker: the actual position follows the
  reference one cycle later, or on every second cycle when slow.
  Assumes one clock and the tracker's reset.
*/
`default_nettype none

module prw_drive_model (
  input  wire logic               clk_i,
  input  wire logic               resetn_i,
  input  wire logic               slow_i,
  input  wire logic signed [63:0] ref_inc_i,
  output logic signed [63:0]      act_inc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tick;

  // Step enable; slow mode halves the follow rate
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) tick <= 1'b0;
    else tick <= ~tick;
  end

  // Actual position lags the reference by one step
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) act_inc_o <= 64'h0;
    else if (!slow_i || tick) act_inc_o <= ref_inc_i;
  end
endmodule : prw_drive_model

`default_nettype wire

// ===== verification/prw_core_assertions.sv
/*
  Checker of the position-range tracker on its top ports.
  Assumes one clock domain; bound to prw_core at the foot.
*/
`default_nettype none

module prw_core_checker
  import prw_pkg::*;
#(
  parameter int unsigned INC_PER_REV = 32768
) (
  input wire logic               clk_i,
  input wire logic               resetn_i,
  input wire prw_mode_t          mode_i,
  input wire prw_cmd_t           cmd_i,
  input wire prw_scale_wr_t      scale_wr_i,
  input wire logic signed [31:0] pos_usr_o,
  input wire logic signed [31:0] target_usr_o,
  input wire logic [31:0]        scale_num_o,
  input wire logic [31:0]        scale_den_o,
  input wire prw_status_t        status_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  property p_rng;
    pos_usr_o[31] == pos_usr_o[30] && target_usr_o[31] == target_usr_o[30];
  endproperty
  a_rng: assert property (p_rng) else $error("position left range");
  property p_mode;
    cmd_i.valid && mode_i == PRW_MODE_OTHER |=> status_o.reject;
  endproperty
  a_mode: assert property (p_mode) else $error("command outside range modes");
  property p_home;
    cmd_i.valid && mode_i != PRW_MODE_HOMING
      && (cmd_i.kind == PRW_CMD_HOME_DONE || cmd_i.kind == PRW_CMD_SET_POS)
      |=> status_o.reject && !$rose(status_o.zero_valid);
  endproperty
  a_home: assert property (p_home) else $error("homing request taken");
  property p_zset;
    cmd_i.valid && mode_i == PRW_MODE_HOMING && cmd_i.kind == PRW_CMD_SET_POS
      && cmd_i.value[31] == cmd_i.value[30] |=> ##[0:1] status_o.zero_valid;
  endproperty
  a_zset: assert property (p_zset) else $error("zero point not set");
  property p_zsrc;
    $rose(status_o.zero_valid) |-> $past(cmd_i.valid) || $past(cmd_i.valid, 2);
  endproperty
  a_zsrc: assert property (p_zsrc) else $error("zero point set alone");
  property p_clr;
    status_o.range_evt |-> ##[0:1] !status_o.zero_valid;
  endproperty
  a_clr: assert property (p_clr) else $error("zero point kept");
  property p_abs;
    cmd_i.valid && cmd_i.kind == PRW_CMD_PP_ABS
      && cmd_i.value[31] != cmd_i.value[30] |=> status_o.reject;
  endproperty
  a_abs: assert property (p_abs) else $error("far absolute move taken");
  property p_den;
    scale_wr_i.den_we && !scale_wr_i.num_we
      |=> $stable(scale_num_o) && $stable(scale_den_o);
  endproperty
  a_den: assert property (p_den) else $error("ratio moved on den write");
  property p_num;
    scale_wr_i.num_we && !scale_wr_i.value[31] && scale_wr_i.value != 32'h0
      |=> scale_num_o == $past(scale_wr_i.value);
  endproperty
  a_num: assert property (p_num) else $error("ratio not taken");

  // Main scenarios reached
  c_evt: cover property (status_o.range_evt);
  c_done: cover property (status_o.done);
  c_zero: cover property ($rose(status_o.zero_valid));
endmodule : prw_core_checker

bind prw_core prw_core_checker #(.INC_PER_REV(INC_PER_REV)) u_prw_core_checker (
  .clk_i(clk_i), .resetn_i(resetn_i), .mode_i(mode_i), .cmd_i(cmd_i),
  .scale_wr_i(scale_wr_i), .pos_usr_o(pos_usr_o), .target_usr_o(target_usr_o),
  .scale_num_o(scale_num_o), .scale_den_o(scale_den_o), .status_o(status_o));

`default_nettype wire

// ===== verification/test_prw_core.sv
/*
  Self-checking bench of the position-range tracker: table of refused
  and taken commands, then moves, wraps, scaling and reset by hand.
  Assumes the drive model closes the position loop.
*/
`default_nettype none

module test_prw_core
  import prw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end
  typedef struct packed {
    prw_mode_t m; prw_cmd_kind_t k; logic [31:0] v; logic r;
  } prw_row_t;

  logic               clk_i = 1'b0;
  logic               resetn_i = 1'b0;
  logic               slow = 1'b0;
  prw_mode_t          mode_i = PRW_MODE_OTHER;
  prw_cmd_t           cmd_i = '0;
  logic [30:0]        speed_i = 31'h00000028;
  prw_scale_wr_t      scale_wr_i = '0;
  logic signed [63:0] act_inc, ref_inc_o;
  logic signed [31:0] pos_usr_o, target_usr_o, act_usr_o;
  logic [31:0]        scale_num_o, scale_den_o;
  prw_status_t        status_o;
  int failures = 0, n_compared = 0, n_rej = 0, n_evt = 0, n_done = 0, dr, de, d0;
  prw_row_t rows[10] = '{
    '{PRW_MODE_OTHER, PRW_CMD_JOG_CONT, 32'h0, 1'b1},
    '{PRW_MODE_JOG, PRW_CMD_PP_ABS, 32'h5, 1'b1},
    '{PRW_MODE_JOG, PRW_CMD_HOME_DONE, 32'h0, 1'b1},
    '{PRW_MODE_PP, PRW_CMD_SET_POS, 32'h0, 1'b1},
    '{PRW_MODE_CSP, PRW_CMD_CSP_SET, 32'h40000000, 1'b1},
    '{PRW_MODE_PP, PRW_CMD_PP_ABS, 32'h40000000, 1'b1},
    '{PRW_MODE_PP, PRW_CMD_PP_ABS, 32'hBFFFFFFF, 1'b1},
    '{PRW_MODE_CSP, PRW_CMD_JOG_STEP, 32'h0, 1'b1},
    '{PRW_MODE_HOMING, PRW_CMD_HOME_DONE, 32'h0, 1'b0},
    '{PRW_MODE_HOMING, PRW_CMD_STOP, 32'h0, 1'b0}};

  always #50 clk_i = ~clk_i;

  prw_core u_prw_core (.clk_i(clk_i), .resetn_i(resetn_i), .mode_i(mode_i),
    .cmd_i(cmd_i), .speed_i(speed_i), .scale_wr_i(scale_wr_i), .act_inc_i(act_inc),
    .pos_usr_o(pos_usr_o), .target_usr_o(target_usr_o), .ref_inc_o(ref_inc_o),
    .act_usr_o(act_usr_o), .scale_num_o(scale_num_o), .scale_den_o(scale_den_o),
    .status_o(status_o));
  prw_drive_model u_prw_drive_model (.clk_i(clk_i), .resetn_i(resetn_i),
    .slow_i(slow), .ref_inc_i(ref_inc_o), .act_inc_o(act_inc));

  // Pulse counters; a one-cycle pulse is never missed this way
  always @(posedge clk_i) begin
    n_rej <= n_rej + status_o.reject;
    n_evt <= n_evt + status_o.range_evt;
    n_done <= n_done + status_o.done;
  end

  task automatic go(input prw_mode_t m, input prw_cmd_kind_t k, input logic [31:0] v);
    int r;
    int e;
    @(posedge clk_i);
    mode_i <= m;
    cmd_i <= {1'b1, k, v};
    #1 r = n_rej;
    e = n_evt;
    d0 = n_done;
    @(posedge clk_i);
    cmd_i.valid <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 dr = n_rej - r;
    de = n_evt - e;
  endtask : go

  // Bounded wait for arrival, then let the outputs settle
  task automatic wait_done();
    for (int i = 0; i < 40 && n_done == d0; i++) @(posedge clk_i);
    `CHK("done", 1'b1, n_done != d0)
    repeat (5) @(posedge clk_i);
    #1;
  endtask : wait_done

  task automatic scl(input logic n, input logic [31:0] v);
    @(posedge clk_i);
    scale_wr_i <= {n, ~n, v};
    @(posedge clk_i);
    scale_wr_i <= '0;
    repeat (4) @(posedge clk_i);
    #1;
  endtask : scl

  task automatic stop_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  // Hang guard, well above the length of the sequence
  initial begin
    repeat (3000) @(posedge clk_i);
    failures++;
    stop_test();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    #1;
    `CHK("status", 5'h00, status_o)
    `CHK("num", 32'h00000001, scale_num_o)
    `CHK("den", 32'h00004000, scale_den_o)
    foreach (rows[i]) begin
      go(rows[i].m, rows[i].k, rows[i].v);
      `CHK("reject", rows[i].r, dr)
    end
    `CHK("zero", 1'b1, status_o.zero_valid)
    $display("table done");
    go(PRW_MODE_PP, PRW_CMD_PP_ABS, 32'h00000064);
    wait_done();
    `CHK("target", 32'h00000064, target_usr_o)
    `CHK("pos", 32'h00000064, pos_usr_o)
    `CHK("ref", 64'h00000000000000C8, ref_inc_o)
    `CHK("act", 32'h00000064, act_usr_o)
    $display("absolute done");
    go(PRW_MODE_CSP, PRW_CMD_CSP_SET, 32'h3FFFFFE8);
    go(PRW_MODE_JOG, PRW_CMD_JOG_CONT, 32'h00000001);
    `CHK("wrap evt", 1'b1, de != 0)
    `CHK("wrap sign", 1'b1, pos_usr_o[31])
    `CHK("busy", 1'b1, status_o.busy)
    `CHK("zero", 1'b0, status_o.zero_valid)
    go(PRW_MODE_JOG, PRW_CMD_STOP, 32'h0);
    $display("wrap done");
    go(PRW_MODE_HOMING, PRW_CMD_SET_POS, 32'h0);
    go(PRW_MODE_CSP, PRW_CMD_CSP_SET, 32'h3FFFFFE8);
    go(PRW_MODE_JOG, PRW_CMD_JOG_STEP, 32'h00000064);
    `CHK("step evt", 1, de)
    `CHK("zero", 1'b0, status_o.zero_valid)
    `CHK("step target", 32'h00000064, target_usr_o)
    wait_done();
    `CHK("step pos", 32'h00000064, pos_usr_o)
    go(PRW_MODE_CSP, PRW_CMD_CSP_SET, 32'hC0000018);
    go(PRW_MODE_PP, PRW_CMD_PP_REL, 32'hFFFFFF9C);
    `CHK("rel evt", 1, de)
    wait_done();
    `CHK("rel pos", 32'hFFFFFF9C, pos_usr_o)
    $display("reset to zero done");
    scl(1'b0, 32'h00002000);
    `CHK("den kept", 32'h00004000, scale_den_o)
    `CHK("ref kept", 64'hFFFFFFFFFFFFFF38, ref_inc_o)
    slow <= 1'b1;
    scl(1'b1, 32'h00000001);
    `CHK("den new", 32'h00002000, scale_den_o)
    `CHK("ref new", 64'hFFFFFFFFFFFFFE70, ref_inc_o)
    repeat (6) @(posedge clk_i);
    #1;
    `CHK("act new", 32'hFFFFFF9C, act_usr_o)
    $display("scaling done");
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK("den rst", 32'h00004000, scale_den_o)
    `CHK("pos rst", 32'h00000000, pos_usr_o)
    `CHK("ref rst", 64'h0, ref_inc_o)
    @(posedge clk_i);
    resetn_i <= 1'b1;
    go(PRW_MODE_HOMING, PRW_CMD_SET_POS, 32'h00000010);
    `CHK("zero back", 1'b1, status_o.zero_valid)
    `CHK("pos back", 32'h00000010, pos_usr_o)
    $display("reset done");
    stop_test();
  end
endmodule : test_prw_core

`default_nettype wire
